//--- prfd_pkg.sv
// prfd_pkg: register map, reset values and carriers of the reference scaling and
// feedback divider block. assumes a 32-bit apb master; indices are word numbers.
package prfd_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_LOOP_CTRL = 10'h101;
  localparam logic [9:0] IDX_CP_SET    = 10'h102;
  localparam logic [9:0] IDX_PREDIV    = 10'h105;
  localparam logic [9:0] IDX_AUX_LO    = 10'h10e;
  localparam logic [9:0] IDX_AUX_HI    = 10'h10f;
  localparam logic [9:0] IDX_N_INT     = 10'h130;
  localparam logic [9:0] IDX_N_FRAC    = 10'h131;
  localparam logic [9:0] IDX_N_MOD     = 10'h132;
  localparam logic [9:0] IDX_STATUS    = 10'h140;

  // field positions in loop_mode_and_doubler_ctrl
  localparam int BIT_SDM_PD  = 0;
  localparam int BIT_MODE_LO = 1;
  localparam int BIT_DOUBLER = 3;

  // values after reset
  localparam logic [3:0]  RST_LOOP_CTRL = 4'h0;
  localparam logic [7:0]  RST_CP_SET    = 8'h8d;
  localparam logic [5:0]  RST_PREDIV    = 6'h01;
  localparam logic [11:0] RST_AUX       = 12'h004;
  localparam logic [7:0]  RST_N_INT     = 8'h32;
  localparam logic [23:0] RST_N_FRAC    = 24'h000000;
  localparam logic [23:0] RST_N_MOD     = 24'h000001;

  // low-rate mode forces 1024 uA, in 4 uA steps
  localparam logic [8:0]  CP_LOWRATE_CODE = 9'h100;

  typedef enum logic [1:0] {
    PRFD_LOOP_FRAC,
    PRFD_LOOP_LOWRATE,
    PRFD_LOOP_ZDELAY,
    PRFD_LOOP_RSVD
  } prfd_loop_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } prfd_apb_req_s;

endpackage

//--- prfd_divider.sv
// prfd_divider: reference doubler/predivider, loop mode decode, integer feedback
// divider with third-order sigma-delta dither, auxiliary cascade divider, apb registers.
// assumes ref_level, osc_tick and zd_fb_tick are synchronous to ref_clk; osc_tick is
// a one-cycle pulse per oscillator cycle, already scaled to the ref_clk domain.
//
// Behaviour
// - doubler set gives pfd pulses at twice reference rate, predivider bypassed
// - doubler clear divides reference by six-bit predivider ratio
// - mode 00 fractional, 01 low-rate cascade, 10 zero delay, 11 reserved
// - only modes 00 and 11 divide by integer plus fraction over modulus via dither
// - modulator power-down forces integer division and numerator treated zero
// - zero numerator with modulator on divides integer, modulator keeps running
// - mode 01 cascades integer divider with auxiliary divider
// - mode 01 forces 1024 uA charge pump and low-rate filter arrangement
// - auxiliary ratio is twelve bits, low byte then low nibble of next
// - auxiliary divider divides by its value for settings 4 to 4095
// - mode 10 feeds detector from zero-delay channel divider
// - fractional section is a third-order sigma-delta modulator
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module prfd_divider #(
  parameter int FRAC_W = 24,
  parameter int AUX_W  = 12
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire prfd_pkg::prfd_apb_req_s apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic                  ref_level,
  input  wire logic                  osc_tick,
  input  wire logic                  zd_fb_tick,
  output logic                       pfd_ref_pulse,
  output logic                       pfd_fb_pulse,
  output logic [8:0]                 cp_code,
  output logic                       lowrate_filter,
  output logic                       sdm_pwrdn
);

  initial begin
    if (FRAC_W != 24 || AUX_W != 12) begin
      $error("prfd_divider: register layout fixes FRAC_W=24 and AUX_W=12");
    end
  end

  // registers
  logic [3:0]        loop_ctrl_q, loop_ctrl_d;
  logic [7:0]        cp_set_q, cp_set_d;
  logic [5:0]        prediv_q, prediv_d;
  logic [AUX_W-1:0]  aux_q, aux_d;
  logic [7:0]        n_int_q, n_int_d;
  logic [FRAC_W-1:0] n_frac_q, n_frac_d;
  logic [FRAC_W-1:0] n_mod_q, n_mod_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  logic [31:0]       prdata_q, prdata_d;

  logic [9:0]        idx;
  logic              wr_fire;
  logic              hit;
  prfd_pkg::prfd_loop_e mode;
  logic [31:0]       status_word;

  assign idx     = apb_req.paddr[11:2];
  assign wr_fire = apb_req.psel & apb_req.penable & pready_q & apb_req.pwrite;
  assign mode    = prfd_pkg::prfd_loop_e'(loop_ctrl_q[prfd_pkg::BIT_MODE_LO +: 2]);

  always_comb begin
    unique case (idx)
      prfd_pkg::IDX_LOOP_CTRL, prfd_pkg::IDX_CP_SET, prfd_pkg::IDX_PREDIV,
      prfd_pkg::IDX_AUX_LO, prfd_pkg::IDX_AUX_HI, prfd_pkg::IDX_N_INT,
      prfd_pkg::IDX_N_FRAC, prfd_pkg::IDX_N_MOD, prfd_pkg::IDX_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // apb slave: one wait state so read data leaves a flip-flop
  always_comb begin
    loop_ctrl_d = loop_ctrl_q;
    cp_set_d    = cp_set_q;
    prediv_d    = prediv_q;
    aux_d       = aux_q;
    n_int_d     = n_int_q;
    n_frac_d    = n_frac_q;
    n_mod_d     = n_mod_q;
    pready_d    = 1'b0;
    pslverr_d   = 1'b0;
    prdata_d    = prdata_q;
    if (apb_req.psel && apb_req.penable && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = ~hit;
      prdata_d  = 32'h0;
      if (!apb_req.pwrite) begin
        unique case (idx)
          prfd_pkg::IDX_LOOP_CTRL: prdata_d = {28'h0, loop_ctrl_q};
          prfd_pkg::IDX_CP_SET:    prdata_d = {24'h0, cp_set_q};
          prfd_pkg::IDX_PREDIV:    prdata_d = {26'h0, prediv_q};
          prfd_pkg::IDX_AUX_LO:    prdata_d = {24'h0, aux_q[7:0]};
          prfd_pkg::IDX_AUX_HI:    prdata_d = {28'h0, aux_q[11:8]};
          prfd_pkg::IDX_N_INT:     prdata_d = {24'h0, n_int_q};
          prfd_pkg::IDX_N_FRAC:    prdata_d = {8'h0, n_frac_q};
          prfd_pkg::IDX_N_MOD:     prdata_d = {8'h0, n_mod_q};
          prfd_pkg::IDX_STATUS:    prdata_d = status_word;
          default:                 prdata_d = 32'h0;
        endcase
      end
    end
    if (wr_fire) begin
      unique case (idx)
        prfd_pkg::IDX_LOOP_CTRL: loop_ctrl_d = apb_req.pwdata[3:0];
        prfd_pkg::IDX_CP_SET:    cp_set_d    = apb_req.pwdata[7:0];
        prfd_pkg::IDX_PREDIV:    prediv_d    = apb_req.pwdata[5:0];
        prfd_pkg::IDX_AUX_LO:    aux_d[7:0]  = apb_req.pwdata[7:0];
        prfd_pkg::IDX_AUX_HI:    aux_d[11:8] = apb_req.pwdata[3:0];
        prfd_pkg::IDX_N_INT:     n_int_d     = apb_req.pwdata[7:0];
        prfd_pkg::IDX_N_FRAC:    n_frac_d    = apb_req.pwdata[23:0];
        prfd_pkg::IDX_N_MOD:     n_mod_d     = apb_req.pwdata[23:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      loop_ctrl_q <= prfd_pkg::RST_LOOP_CTRL;
      cp_set_q    <= prfd_pkg::RST_CP_SET;
      prediv_q    <= prfd_pkg::RST_PREDIV;
      aux_q       <= prfd_pkg::RST_AUX;
      n_int_q     <= prfd_pkg::RST_N_INT;
      n_frac_q    <= prfd_pkg::RST_N_FRAC;
      n_mod_q     <= prfd_pkg::RST_N_MOD;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= 32'h0;
    end else begin
      loop_ctrl_q <= loop_ctrl_d;
      cp_set_q    <= cp_set_d;
      prediv_q    <= prediv_d;
      aux_q       <= aux_d;
      n_int_q     <= n_int_d;
      n_frac_q    <= n_frac_d;
      n_mod_q     <= n_mod_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      prdata_q    <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // reference path
  logic       ref_prev_q, ref_prev_d;
  logic [5:0] pre_cnt_q, pre_cnt_d;
  logic       pfd_ref_q, pfd_ref_d;
  logic       ref_rise, ref_fall;
  logic [5:0] pre_last;

  assign ref_rise = ref_level & ~ref_prev_q;
  assign ref_fall = ~ref_level & ref_prev_q;
  // a zero ratio would stall the loop, so it divides by one
  assign pre_last = (prediv_q == 6'h0) ? 6'h0 : prediv_q - 6'h1;

  always_comb begin
    ref_prev_d = ref_level;
    pre_cnt_d  = pre_cnt_q;
    pfd_ref_d  = 1'b0;
    if (loop_ctrl_q[prfd_pkg::BIT_DOUBLER]) begin
      // both edges make pfd events; spurs follow if the duty is far from half
      pfd_ref_d = ref_rise | ref_fall;
      pre_cnt_d = 6'h0;
    end else if (ref_rise) begin
      if (pre_cnt_q >= pre_last) begin
        pre_cnt_d = 6'h0;
        pfd_ref_d = 1'b1;
      end else begin
        pre_cnt_d = pre_cnt_q + 6'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ref_prev_q <= 1'b0;
      pre_cnt_q  <= 6'h0;
      pfd_ref_q  <= 1'b0;
    end else begin
      ref_prev_q <= ref_prev_d;
      pre_cnt_q  <= pre_cnt_d;
      pfd_ref_q  <= pfd_ref_d;
    end
  end

  assign pfd_ref_pulse = pfd_ref_q;

  // sigma-delta modulator: mash 1-1-1, stepped once per integer divider cycle
  logic [FRAC_W-1:0] acc1_q, acc1_d, acc2_q, acc2_d, acc3_q, acc3_d;
  logic              c2_p_q, c2_p_d, c3_p_q, c3_p_d, c3_pp_q, c3_pp_d;
  logic signed [3:0] dither_q, dither_d;
  logic              sdm_on;
  logic              frac_mode;
  logic              n_done;

  // the reserved code runs the fractional path so the loop stays defined
  assign frac_mode = (mode == prfd_pkg::PRFD_LOOP_FRAC) ||
                     (mode == prfd_pkg::PRFD_LOOP_RSVD);
  // powered down, the numerator counts as zero; a zero numerator keeps it running
  assign sdm_on    = frac_mode & ~loop_ctrl_q[prfd_pkg::BIT_SDM_PD];

  function automatic logic [FRAC_W:0] mod_add(input logic [FRAC_W-1:0] a,
                                             input logic [FRAC_W-1:0] b,
                                             input logic [FRAC_W-1:0] m);
    logic [FRAC_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, m}) begin
      mod_add = {1'b1, FRAC_W'(s - {1'b0, m})};
    end else begin
      mod_add = {1'b0, s[FRAC_W-1:0]};
    end
  endfunction

  always_comb begin
    logic [FRAC_W:0] s1, s2, s3;
    s1       = mod_add(acc1_q, n_frac_q, n_mod_q);
    s2       = mod_add(acc2_q, s1[FRAC_W-1:0], n_mod_q);
    s3       = mod_add(acc3_q, s2[FRAC_W-1:0], n_mod_q);
    acc1_d   = acc1_q;
    acc2_d   = acc2_q;
    acc3_d   = acc3_q;
    c2_p_d   = c2_p_q;
    c3_p_d   = c3_p_q;
    c3_pp_d  = c3_pp_q;
    dither_d = dither_q;
    if (!sdm_on) begin
      acc1_d   = '0;
      acc2_d   = '0;
      acc3_d   = '0;
      c2_p_d   = 1'b0;
      c3_p_d   = 1'b0;
      c3_pp_d  = 1'b0;
      dither_d = 4'sh0;
    end else if (n_done) begin
      acc1_d   = s1[FRAC_W-1:0];
      acc2_d   = s2[FRAC_W-1:0];
      acc3_d   = s3[FRAC_W-1:0];
      c2_p_d   = s2[FRAC_W];
      c3_p_d   = s3[FRAC_W];
      c3_pp_d  = c3_p_q;
      // offset in -3..+4 averages to fraction over modulus
      dither_d = $signed({3'b000, s1[FRAC_W]}) + $signed({3'b000, s2[FRAC_W]})
               - $signed({3'b000, c2_p_q}) + $signed({3'b000, s3[FRAC_W]})
               - $signed({2'b00, c3_p_q, 1'b0}) + $signed({3'b000, c3_pp_q});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc1_q   <= '0;
      acc2_q   <= '0;
      acc3_q   <= '0;
      c2_p_q   <= 1'b0;
      c3_p_q   <= 1'b0;
      c3_pp_q  <= 1'b0;
      dither_q <= 4'sh0;
    end else begin
      acc1_q   <= acc1_d;
      acc2_q   <= acc2_d;
      acc3_q   <= acc3_d;
      c2_p_q   <= c2_p_d;
      c3_p_q   <= c3_p_d;
      c3_pp_q  <= c3_pp_d;
      dither_q <= dither_d;
    end
  end

  // feedback dividers
  logic [8:0]       n_cnt_q, n_cnt_d;
  logic [AUX_W-1:0] aux_cnt_q, aux_cnt_d;
  logic             fb_q, fb_d;
  logic [8:0]       n_ratio;

  // the dither already carries the full second difference of the last carry,
  // so adding a delayed carry here again would bias the average ratio
  assign n_ratio = 9'({1'b0, n_int_q} + {{5{dither_q[3]}}, dither_q});
  assign n_done  = osc_tick && (n_cnt_q + 9'h1 >= n_ratio);

  always_comb begin
    n_cnt_d   = n_cnt_q;
    aux_cnt_d = aux_cnt_q;
    fb_d      = 1'b0;
    if (osc_tick) begin
      n_cnt_d = n_done ? 9'h0 : n_cnt_q + 9'h1;
    end
    unique case (mode)
      prfd_pkg::PRFD_LOOP_LOWRATE: begin
        if (n_done) begin
          if (aux_cnt_q + 12'h1 >= aux_q) begin
            aux_cnt_d = '0;
            fb_d      = 1'b1;
          end else begin
            aux_cnt_d = aux_cnt_q + 12'h1;
          end
        end
      end
      prfd_pkg::PRFD_LOOP_ZDELAY: begin
        fb_d      = zd_fb_tick;
        aux_cnt_d = '0;
      end
      default: begin
        fb_d      = n_done;
        aux_cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      n_cnt_q   <= 9'h0;
      aux_cnt_q <= '0;
      fb_q      <= 1'b0;
    end else begin
      n_cnt_q   <= n_cnt_d;
      aux_cnt_q <= aux_cnt_d;
      fb_q      <= fb_d;
    end
  end

  assign pfd_fb_pulse = fb_q;

  // loop-mode overrides toward the analogue side
  logic [8:0] cp_q, cp_d;
  logic       lowrate_q, lowrate_d;
  logic       pd_q, pd_d;

  always_comb begin
    lowrate_d = (mode == prfd_pkg::PRFD_LOOP_LOWRATE);
    cp_d      = lowrate_d ? prfd_pkg::CP_LOWRATE_CODE : {1'b0, cp_set_q};
    pd_d      = ~sdm_on;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cp_q      <= {1'b0, prfd_pkg::RST_CP_SET};
      lowrate_q <= 1'b0;
      pd_q      <= 1'b0;
    end else begin
      cp_q      <= cp_d;
      lowrate_q <= lowrate_d;
      pd_q      <= pd_d;
    end
  end

  assign cp_code        = cp_q;
  assign lowrate_filter = lowrate_q;
  assign sdm_pwrdn      = pd_q;

  assign status_word = {16'h0, 3'h0, lowrate_q, sdm_on, 1'b0, loop_ctrl_q[2:1], n_int_q};

endmodule

//--- prfd_divider_monitor.sv
// prfd_divider_monitor: concurrent checks on the ports of prfd_divider.
// assumes register writes land at the edge where pready is sampled high.
`timescale 1ns/1ps
module prfd_divider_monitor (
  input wire logic                    ref_clk,
  input wire logic                    rst_b,
  input wire prfd_pkg::prfd_apb_req_s apb_req,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    ref_level,
  input wire logic                    osc_tick,
  input wire logic                    zd_fb_tick,
  input wire logic                    pfd_ref_pulse,
  input wire logic                    pfd_fb_pulse,
  input wire logic [8:0]              cp_code,
  input wire logic                    lowrate_filter,
  input wire logic                    sdm_pwrdn
);
  logic [3:0] ctrl_q;
  logic [1:0] settle_q;
  logic       wr_done;
  logic       ok;
  assign wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
  // outputs lag control writes, so judge only once the mirror has settled
  assign ok = settle_q == 2'h3 && !pready;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_q   <= prfd_pkg::RST_LOOP_CTRL;
      settle_q <= 2'h0;
    end else begin
      if (wr_done && !pslverr && apb_req.paddr[11:2] == prfd_pkg::IDX_LOOP_CTRL) begin
        ctrl_q <= apb_req.pwdata[3:0];
      end
      settle_q <= wr_done ? 2'h0 : settle_q + {1'b0, settle_q != 2'h3};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_dbl_rise; ok && ctrl_q[3] && $rose(ref_level) |=> pfd_ref_pulse; endproperty
  a_dbl_rise: assert property (p_dbl_rise) else $error("no pulse on reference rise");
  property p_dbl_fall; ok && ctrl_q[3] && $fell(ref_level) |=> pfd_ref_pulse; endproperty
  a_dbl_fall: assert property (p_dbl_fall) else $error("no pulse on reference fall");
  property p_div_fall; ok && !ctrl_q[3] && $fell(ref_level) |=> !pfd_ref_pulse; endproperty
  a_div_fall: assert property (p_div_fall) else $error("pulse on fall while dividing");
  property p_div_src; pfd_ref_pulse && ok && !ctrl_q[3] |-> $past(ref_level) && !$past(ref_level, 2); endproperty
  a_div_src: assert property (p_div_src) else $error("divided pulse without a rise");
  property p_lowrate; ok && ctrl_q[2:1] == 2'h1 |-> cp_code == prfd_pkg::CP_LOWRATE_CODE && lowrate_filter; endproperty
  a_lowrate: assert property (p_lowrate) else $error("low-rate overrides missing");
  property p_other; ok && ctrl_q[2:1] != 2'h1 |-> !lowrate_filter; endproperty
  a_other: assert property (p_other) else $error("low-rate filter outside mode 01");
  property p_pd; ok && ctrl_q[0] |-> sdm_pwrdn; endproperty
  a_pd: assert property (p_pd) else $error("modulator not powered down");
  property p_run; ok && !ctrl_q[0] && ctrl_q[2] == ctrl_q[1] |-> !sdm_pwrdn; endproperty
  a_run: assert property (p_run) else $error("modulator stopped in mode 00 or 11");
  property p_zd; ok && ctrl_q[2:1] == 2'h2 |=> pfd_fb_pulse == $past(zd_fb_tick); endproperty
  a_zd: assert property (p_zd) else $error("zero-delay feedback not followed");
  property p_fb_src; pfd_fb_pulse && ok && ctrl_q[2:1] != 2'h2 |-> $past(osc_tick); endproperty
  a_fb_src: assert property (p_fb_src) else $error("feedback pulse without tick");
endmodule
bind prfd_divider prfd_divider_monitor prfd_divider_monitor_inst (.ref_clk(ref_clk),
  .rst_b(rst_b), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
  .ref_level(ref_level), .osc_tick(osc_tick), .zd_fb_tick(zd_fb_tick),
  .pfd_ref_pulse(pfd_ref_pulse), .pfd_fb_pulse(pfd_fb_pulse), .cp_code(cp_code),
  .lowrate_filter(lowrate_filter), .sdm_pwrdn(sdm_pwrdn));

//--- prfd_ref_source.sv
// prfd_ref_source: free-running reference clock, as a level sampled on ref_clk.
// assumes half_cyc counts ref_clk cycles per half period; zero holds it low.
`timescale 1ns/1ps
module prfd_ref_source (
  input  wire logic       ref_clk,
  input  wire logic [5:0] half_cyc,
  output logic            ref_level
);
  logic [5:0] cnt_q;
  always_ff @(posedge ref_clk) begin
    if (half_cyc == 6'h00) begin
      ref_level <= 1'b0;
      cnt_q     <= 6'h00;
    end else if (cnt_q + 6'h01 >= half_cyc) begin
      ref_level <= !ref_level;
      cnt_q     <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule

//--- prfd_divider_bench.sv
// prfd_divider_bench: apb-driven tests of prfd_divider with a reference source.
// assumes the monitor is bound to prfd_divider; ref_clk runs at 250 MHz.
`timescale 1ns/1ps
module prfd_divider_bench;
  logic                    ref_clk;
  logic                    rst_b;
  prfd_pkg::prfd_apb_req_s req;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  logic                    ref_level;
  logic                    osc_tick;
  logic                    zd_fb_tick = 1'b0;
  logic                    zd_en;
  logic                    pfd_ref_pulse;
  logic                    pfd_fb_pulse;
  logic [8:0]              cp_code;
  logic                    lowrate_filter;
  logic                    sdm_pwrdn;
  logic [5:0]              half_cyc;
  logic [31:0]             rdata;
  logic                    rerr;
  int                      mismatches;
  int                      check_count;
  int                      cyc = 0;
  int                      rv[3] = '{1, 3, 63};

  prfd_divider prfd_divider_inst (.ref_clk(ref_clk), .rst_b(rst_b), .apb_req(req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ref_level(ref_level),
    .osc_tick(osc_tick), .zd_fb_tick(zd_fb_tick), .pfd_ref_pulse(pfd_ref_pulse),
    .pfd_fb_pulse(pfd_fb_pulse), .cp_code(cp_code), .lowrate_filter(lowrate_filter),
    .sdm_pwrdn(sdm_pwrdn));
  prfd_ref_source prfd_ref_source_inst (.ref_clk(ref_clk), .half_cyc(half_cyc),
    .ref_level(ref_level));

  always #2 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    zd_fb_tick <= zd_en && (cyc % 7 == 0);
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after a rising edge; leaves one idle cycle so psel is never set twice
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, 32'(pready));
    rdata = prdata;
    rerr  = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input string what, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rdata);
  endtask

  // syncs on two pulses, since the first gap after a change may be partial
  // the wait limit is per pulse, so a long first partial gap cannot cut the next one
  task automatic gaps(input logic fb, input int k, input string what, input int exp);
    int g;
    int w;
    g = 0;
    for (int i = 0; i <= k + 1; i++) begin
      if (i == 2) g = 0;
      w = 0;
      do begin
        @(posedge ref_clk);
        g++;
        w++;
      end while ((fb ? pfd_fb_pulse : pfd_ref_pulse) !== 1'b1 && w < 4000);
    end
    chk(what, exp, g);
  endtask

  initial begin
    ref_clk     = 1'b0;
    rst_b       = 1'b0;
    req         = '0;
    osc_tick    = 1'b0;
    zd_en       = 1'b0;
    half_cyc    = 6'h00;
    mismatches  = 0;
    check_count = 0;
    repeat (4) @(posedge ref_clk);
    rst_b    <= 1'b1;
    osc_tick <= 1'b1;
    half_cyc <= 6'h02;
    @(posedge ref_clk);
    chk("cp_rst", 32'(prfd_pkg::RST_CP_SET), 32'(cp_code));
    rd("ctrl", prfd_pkg::IDX_LOOP_CTRL, 32'h0);
    rd("prediv", prfd_pkg::IDX_PREDIV, 32'h1);
    rd("aux_lo", prfd_pkg::IDX_AUX_LO, 32'h4);
    rd("aux_hi", prfd_pkg::IDX_AUX_HI, 32'h0);
    rd("n_int", prfd_pkg::IDX_N_INT, 32'h32);
    rd("mod", prfd_pkg::IDX_N_MOD, 32'h1);
    apb(1'b1, 10'h1ff, 32'hffff_ffff);
    chk("err_wr", 32'h1, 32'(rerr));
    rd("hole", 10'h1ff, 32'h0);
    chk("err_rd", 32'h1, 32'(rerr));
    apb(1'b1, prfd_pkg::IDX_AUX_HI, 32'hab);
    rd("aux_hi", prfd_pkg::IDX_AUX_HI, 32'hb);
    apb(1'b1, prfd_pkg::IDX_N_INT, 32'h0c);
    gaps(1'b1, 2, "fb_int", 24);
    chk("sdm_on", 32'h0, 32'(sdm_pwrdn));
    apb(1'b1, prfd_pkg::IDX_N_INT, 32'h0f);
    // one half, scaled up so the modulus is as large as it can be
    apb(1'b1, prfd_pkg::IDX_N_MOD, 32'h00ff_fffe);
    apb(1'b1, prfd_pkg::IDX_N_FRAC, 32'h007f_ffff);
    gaps(1'b1, 8, "fb_frac", 124);
    apb(1'b1, prfd_pkg::IDX_LOOP_CTRL, 32'h1);
    gaps(1'b1, 2, "fb_pd", 30);
    chk("sdm_off", 32'h1, 32'(sdm_pwrdn));
    apb(1'b1, prfd_pkg::IDX_LOOP_CTRL, 32'h6);
    gaps(1'b1, 8, "fb_rsvd", 124);
    apb(1'b1, prfd_pkg::IDX_LOOP_CTRL, 32'h3);
    apb(1'b1, prfd_pkg::IDX_N_INT, 32'h0c);
    apb(1'b1, prfd_pkg::IDX_AUX_LO, 32'h04);
    apb(1'b1, prfd_pkg::IDX_AUX_HI, 32'h0);
    gaps(1'b1, 1, "fb_aux4", 48);
    chk("cp_ovr", 32'h100, 32'(cp_code));
    chk("lowrate", 32'h1, 32'(lowrate_filter));
    rd("status", prfd_pkg::IDX_STATUS, 32'h0000_110c);
    apb(1'b1, prfd_pkg::IDX_AUX_LO, 32'h00);
    apb(1'b1, prfd_pkg::IDX_AUX_HI, 32'h1);
    gaps(1'b1, 1, "fb_aux256", 3072);
    zd_en <= 1'b1;
    apb(1'b1, prfd_pkg::IDX_LOOP_CTRL, 32'h5);
    gaps(1'b1, 2, "fb_zd", 14);
    apb(1'b1, prfd_pkg::IDX_LOOP_CTRL, 32'h0);
    apb(1'b1, prfd_pkg::IDX_CP_SET, 32'h22);
    repeat (2) @(posedge ref_clk);
    chk("cp_set", 32'h22, 32'(cp_code));
    chk("lowrate", 32'h0, 32'(lowrate_filter));
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, prfd_pkg::IDX_PREDIV, 32'(rv[i]));
      gaps(1'b0, 1, "ref_div", 4 * rv[i]);
    end
    half_cyc <= 6'h03;
    apb(1'b1, prfd_pkg::IDX_LOOP_CTRL, 32'h8);
    gaps(1'b0, 2, "ref_dbl", 6);
    tally_and_finish();
  end
endmodule
